// ---- logic/rpf_pkg.sv ----
// Overview of operation
// - Six tests: station address, pattern checksum, wake-up, hash, group and all-ones address.
// - Any mix of tests may be enabled together, each by its own control bit.
// - AND select: accept only when every enabled test passes, else discard.
// - OR select: accept when any enabled test passes and the FCS is good or the CRC check is off; discard when all enabled tests fail.
// - Control register all zero means promiscuous: every frame is accepted.
// - Station test: AND mode discards non-matching destinations; OR mode accepts a match with a good FCS or the CRC check off.
// - One read/write 8-bit control register holds all enables and the combine select.
// - Station test passes only on an exact destination match with the programmed address.
// - Pattern test: checksum of up to 64 selected bytes equals the reference.
`default_nettype none

package rpf_pkg;
	localparam logic [7:0]  RPF_CTRL_OFS     = 8'h00;
	localparam logic [7:0]  RPF_STA_LO_OFS   = 8'h04;
	localparam logic [7:0]  RPF_STA_HI_OFS   = 8'h08;
	localparam logic [7:0]  RPF_PMASK_LO_OFS = 8'h0c;
	localparam logic [7:0]  RPF_PMASK_HI_OFS = 8'h10;
	localparam logic [7:0]  RPF_POFS_OFS     = 8'h14;
	localparam logic [7:0]  RPF_PREF_OFS     = 8'h18;
	localparam logic [7:0]  RPF_STAT_OFS     = 8'h1c;

	localparam logic [7:0]  RPF_CTRL_RESET   = 8'ha1;
	localparam logic [47:0] RPF_STA_RESET    = 48'h0;
	localparam logic [63:0] RPF_PMASK_RESET  = 64'h0;
	localparam logic [10:0] RPF_POFS_RESET   = 11'h0;
	localparam logic [15:0] RPF_PREF_RESET   = 16'h0;

	localparam int RPF_BIT_STA  = 7;
	localparam int RPF_BIT_COMB = 6;
	localparam int RPF_BIT_CRC  = 5;
	localparam int RPF_BIT_PAT  = 4;
	localparam int RPF_BIT_WAKE = 3;
	localparam int RPF_BIT_HASH = 2;
	localparam int RPF_BIT_GRP  = 1;
	localparam int RPF_BIT_ALL1 = 0;
	localparam int RPF_STAT_VERDICT_BIT = 16;

	localparam logic [10:0] RPF_DA_LEN      = 11'h006;
	localparam logic [10:0] RPF_PAT_WINDOW  = 11'h040;
	localparam logic [47:0] RPF_ALL1_ADDR   = 48'hffff_ffff_ffff;

	typedef enum logic [2:0] {
		RPF_ST_IDLE  = 3'b001,
		RPF_ST_RECV  = 3'b010,
		RPF_ST_JUDGE = 3'b100
	} rpf_state_type;
endpackage : rpf_pkg

`default_nettype wire

// ---- logic/rpf_csum.sv ----
`default_nettype none

// Internet checksum over a byte stream; even bytes form the high half of each 16-bit word.
module rpf_csum (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        clear_in,
	input  wire logic        byte_valid_in,
	input  wire logic [7:0]  byte_in,
	output logic      [15:0] csum_out
);
	logic [15:0] acc_r;
	logic [15:0] acc_nxt;
	logic        pend_r;
	logic        pend_nxt;
	logic [7:0]  hi_r;
	logic [7:0]  hi_nxt;

	function automatic logic [15:0] rpf_add1c(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0, s[16]};
	endfunction : rpf_add1c

	always_comb begin
		acc_nxt = clear_in ? 16'h0 : acc_r;
		pend_nxt = clear_in ? 1'b0 : pend_r;
		hi_nxt = hi_r;
		if (byte_valid_in) begin
			if (!pend_nxt) begin
				hi_nxt = byte_in;
				pend_nxt = 1'b1;
			end else begin
				acc_nxt = rpf_add1c(acc_nxt, {hi_r, byte_in});
				pend_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_r <= 16'h0;
			pend_r <= 1'b0;
			hi_r <= 8'h0;
		end else begin
			acc_r <= acc_nxt;
			pend_r <= pend_nxt;
			hi_r <= hi_nxt;
		end
	end

	// An odd trailing byte is padded with a zero low half.
	assign csum_out = ~(pend_r ? rpf_add1c(acc_r, {hi_r, 8'h0}) : acc_r);
endmodule : rpf_csum

`default_nettype wire

// ---- logic/rx_packet_filter.sv ----
`default_nettype none

module rx_packet_filter (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rx_valid_in,
	input  wire logic        rx_start_in,
	input  wire logic        rx_end_in,
	input  wire logic [7:0]  rx_byte_in,
	input  wire logic        rx_crc_ok_in,
	input  wire logic        hash_match_in,
	input  wire logic        wakeup_match_in,
	output logic             verdict_valid_out,
	output logic             frame_accept_out
);
	logic [7:0]  receive_filter_control_r, receive_filter_control_nxt;
	logic [47:0] local_station_addr_r, local_station_addr_nxt;
	logic [63:0] pattern_mask_r, pattern_mask_nxt;
	logic [10:0] pattern_offset_r, pattern_offset_nxt;
	logic [15:0] pattern_checksum_ref_r, pattern_checksum_ref_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	rpf_pkg::rpf_state_type state_r, state_nxt;
	logic [10:0] cnt_r, cnt_nxt;
	logic [47:0] dest_r, dest_nxt;
	logic        crc_ok_r, crc_ok_nxt;
	logic        hash_r, hash_nxt;
	logic        wake_r, wake_nxt;
	logic        verdict_r, verdict_nxt;
	logic        vvalid_r, vvalid_nxt;
	logic [15:0] last_csum_r, last_csum_nxt;

	logic        bus_wr;
	logic        mapped;
	logic [10:0] idx;
	logic [10:0] rel;
	logic        pat_sel;
	logic [15:0] csum;
	logic        da_ok;
	logic [5:0]  en;
	logic [5:0]  pass;
	logic        combined;
	logic        accept;

	function automatic logic rpf_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : rpf_hit

	// Zero-wait slave: read data is latched in the setup cycle so it is a flop during access.
	assign pready_out = 1'b1;
	assign bus_wr = psel_in && penable_in && pwrite_in;
	assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= rpf_pkg::RPF_STAT_OFS);
	assign pslverr_out = psel_in && penable_in && !mapped;
	assign prdata_out = prdata_r;

	always_comb begin
		receive_filter_control_nxt = receive_filter_control_r;
		local_station_addr_nxt = local_station_addr_r;
		pattern_mask_nxt = pattern_mask_r;
		pattern_offset_nxt = pattern_offset_r;
		pattern_checksum_ref_nxt = pattern_checksum_ref_r;
		prdata_nxt = prdata_r;
		if (bus_wr) begin
			if (rpf_hit(paddr_in, rpf_pkg::RPF_CTRL_OFS)) receive_filter_control_nxt = pwdata_in[7:0];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_STA_LO_OFS)) local_station_addr_nxt[31:0] = pwdata_in;
			if (rpf_hit(paddr_in, rpf_pkg::RPF_STA_HI_OFS)) local_station_addr_nxt[47:32] = pwdata_in[15:0];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PMASK_LO_OFS)) pattern_mask_nxt[31:0] = pwdata_in;
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PMASK_HI_OFS)) pattern_mask_nxt[63:32] = pwdata_in;
			if (rpf_hit(paddr_in, rpf_pkg::RPF_POFS_OFS)) pattern_offset_nxt = pwdata_in[10:0];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PREF_OFS)) pattern_checksum_ref_nxt = pwdata_in[15:0];
		end
		if (psel_in && !penable_in && !pwrite_in) begin
			prdata_nxt = 32'h0;
			if (rpf_hit(paddr_in, rpf_pkg::RPF_CTRL_OFS)) prdata_nxt = {24'h0, receive_filter_control_r};
			if (rpf_hit(paddr_in, rpf_pkg::RPF_STA_LO_OFS)) prdata_nxt = local_station_addr_r[31:0];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_STA_HI_OFS)) prdata_nxt = {16'h0, local_station_addr_r[47:32]};
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PMASK_LO_OFS)) prdata_nxt = pattern_mask_r[31:0];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PMASK_HI_OFS)) prdata_nxt = pattern_mask_r[63:32];
			if (rpf_hit(paddr_in, rpf_pkg::RPF_POFS_OFS)) prdata_nxt = {21'h0, pattern_offset_r};
			if (rpf_hit(paddr_in, rpf_pkg::RPF_PREF_OFS)) prdata_nxt = {16'h0, pattern_checksum_ref_r};
			if (rpf_hit(paddr_in, rpf_pkg::RPF_STAT_OFS)) prdata_nxt = {15'h0, verdict_r, last_csum_r};
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			receive_filter_control_r <= rpf_pkg::RPF_CTRL_RESET;
			local_station_addr_r <= rpf_pkg::RPF_STA_RESET;
			pattern_mask_r <= rpf_pkg::RPF_PMASK_RESET;
			pattern_offset_r <= rpf_pkg::RPF_POFS_RESET;
			pattern_checksum_ref_r <= rpf_pkg::RPF_PREF_RESET;
			prdata_r <= 32'h0;
		end else begin
			receive_filter_control_r <= receive_filter_control_nxt;
			local_station_addr_r <= local_station_addr_nxt;
			pattern_mask_r <= pattern_mask_nxt;
			pattern_offset_r <= pattern_offset_nxt;
			pattern_checksum_ref_r <= pattern_checksum_ref_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Byte index within the frame; a start byte always restarts at zero, aborting any frame in flight.
	assign idx = rx_start_in ? 11'h0 : cnt_r;
	assign rel = idx - pattern_offset_r;
	assign pat_sel = rx_valid_in && (rx_start_in || state_r == rpf_pkg::RPF_ST_RECV) &&
		(idx >= pattern_offset_r) && (rel < rpf_pkg::RPF_PAT_WINDOW) && pattern_mask_r[rel[5:0]];

	rpf_csum rpf_csum_inst (
		.clk_in        (clk_in),
		.arst_n_in     (arst_n_in),
		.clear_in      (rx_valid_in && rx_start_in),
		.byte_valid_in (pat_sel),
		.byte_in       (rx_byte_in),
		.csum_out      (csum)
	);

	// Evaluation of the six tests, done in the cycle after the last byte so the checksum is complete.
	assign da_ok = cnt_r >= rpf_pkg::RPF_DA_LEN;
	assign en = {receive_filter_control_r[rpf_pkg::RPF_BIT_STA], receive_filter_control_r[rpf_pkg::RPF_BIT_PAT],
		receive_filter_control_r[rpf_pkg::RPF_BIT_WAKE], receive_filter_control_r[rpf_pkg::RPF_BIT_HASH],
		receive_filter_control_r[rpf_pkg::RPF_BIT_GRP], receive_filter_control_r[rpf_pkg::RPF_BIT_ALL1]};
	assign pass = {da_ok && (dest_r == local_station_addr_r),
		csum == pattern_checksum_ref_r, wake_r, hash_r,
		da_ok && dest_r[0], da_ok && (dest_r == rpf_pkg::RPF_ALL1_ADDR)};
	// With nothing enabled both modes accept, which gives promiscuous operation for free.
	assign combined = receive_filter_control_r[rpf_pkg::RPF_BIT_COMB] ? &(~en | pass)
		: ((en == 6'h0) || |(en & pass));
	assign accept = combined && (!receive_filter_control_r[rpf_pkg::RPF_BIT_CRC] || crc_ok_r);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		dest_nxt = dest_r;
		crc_ok_nxt = crc_ok_r;
		hash_nxt = hash_r;
		wake_nxt = wake_r;
		verdict_nxt = verdict_r;
		vvalid_nxt = 1'b0;
		last_csum_nxt = last_csum_r;
		case (state_r)
			rpf_pkg::RPF_ST_IDLE, rpf_pkg::RPF_ST_RECV, rpf_pkg::RPF_ST_JUDGE: begin
				if (state_r == rpf_pkg::RPF_ST_JUDGE) begin
					verdict_nxt = accept;
					vvalid_nxt = 1'b1;
					last_csum_nxt = csum;
					state_nxt = rpf_pkg::RPF_ST_IDLE;
				end
				if (rx_valid_in && (rx_start_in || state_r == rpf_pkg::RPF_ST_RECV)) begin
					if (idx < rpf_pkg::RPF_DA_LEN) dest_nxt[{idx[2:0], 3'b000} +: 8] = rx_byte_in;
					if (idx != 11'h7ff) cnt_nxt = idx + 11'h1;
					state_nxt = rpf_pkg::RPF_ST_RECV;
					if (rx_end_in) begin
						crc_ok_nxt = rx_crc_ok_in;
						hash_nxt = hash_match_in;
						wake_nxt = wakeup_match_in;
						state_nxt = rpf_pkg::RPF_ST_JUDGE;
					end
				end
			end
			default: state_nxt = rpf_pkg::RPF_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= rpf_pkg::RPF_ST_IDLE;
			cnt_r <= 11'h0;
			dest_r <= 48'h0;
			crc_ok_r <= 1'b0;
			hash_r <= 1'b0;
			wake_r <= 1'b0;
			verdict_r <= 1'b0;
			vvalid_r <= 1'b0;
			last_csum_r <= 16'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			dest_r <= dest_nxt;
			crc_ok_r <= crc_ok_nxt;
			hash_r <= hash_nxt;
			wake_r <= wake_nxt;
			verdict_r <= verdict_nxt;
			vvalid_r <= vvalid_nxt;
			last_csum_r <= last_csum_nxt;
		end
	end

	assign verdict_valid_out = vvalid_r;
	assign frame_accept_out = verdict_r;

	default clocking rpf_cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	logic judge;
	logic [7:0] ctl;
	assign judge = state_r == rpf_pkg::RPF_ST_JUDGE;
	assign ctl = receive_filter_control_r;

	promisc_accept_a: assert property (judge && ctl == 8'h00 |=> vvalid_r && verdict_r)
		else $error("promiscuous frame not accepted");
	and_reject_a: assert property (judge && ctl[6] && |(en & ~pass) |=> vvalid_r && !verdict_r)
		else $error("AND mode accepted a frame failing an enabled test");
	or_accept_a: assert property (judge && !ctl[6] && |(en & pass) && (!ctl[5] || crc_ok_r) |=> verdict_r)
		else $error("OR mode discarded a frame passing an enabled test");
	or_reject_a: assert property (judge && !ctl[6] && en != 6'h0 && !(|(en & pass)) |=> !verdict_r)
		else $error("OR mode accepted a frame all tests rejected");
	crc_reject_a: assert property (judge && ctl[5] && !crc_ok_r |=> vvalid_r && !verdict_r)
		else $error("bad FCS frame accepted");
	sta_mismatch_a: assert property (judge && ctl[6] && ctl[7] && dest_r != local_station_addr_r |=> !verdict_r)
		else $error("station mismatch accepted in AND mode");
	sta_or_a: assert property (judge && !ctl[6] && ctl[7] && !ctl[5] && da_ok
		&& dest_r == local_station_addr_r |=> verdict_r)
		else $error("station match discarded in OR mode");
	pat_mismatch_a: assert property (judge && ctl[6] && ctl[4] && csum != pattern_checksum_ref_r |=> !verdict_r)
		else $error("pattern mismatch accepted in AND mode");
	ctrl_write_a: assert property (bus_wr && paddr_in == rpf_pkg::RPF_CTRL_OFS
		|=> receive_filter_control_r == $past(pwdata_in[7:0]))
		else $error("control register write lost");
	verdict_once_a: assert property (rx_valid_in && rx_end_in && !rx_start_in && state_r == rpf_pkg::RPF_ST_RECV
		|=> !vvalid_r ##1 vvalid_r ##1 !vvalid_r)
		else $error("verdict not a single pulse two cycles after frame end");

	and_accept_c: cover property (judge && ctl[6] && en != 6'h0 ##1 verdict_r);
	or_accept_c: cover property (judge && !ctl[6] && en != 6'h0 ##1 verdict_r);
	discard_c: cover property (vvalid_r && !verdict_r);
	promisc_c: cover property (judge && ctl == 8'h00);
endmodule : rx_packet_filter

`default_nettype wire

// ---- tb/rpf_rx_src.sv ----
`default_nettype none

// Receive datapath model: eight-byte frames, qualifiers shown only with the end byte.
module rpf_rx_src (
	input  wire logic       clk_in,
	output logic            rx_valid_out,
	output logic            rx_start_out,
	output logic            rx_end_out,
	output logic      [7:0] rx_byte_out,
	output logic            rx_crc_ok_out,
	output logic            hash_match_out,
	output logic            wakeup_match_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid_out = 1'b0;
		rx_start_out = 1'b0;
		rx_end_out = 1'b0;
		rx_byte_out = 8'h00;
		rx_crc_ok_out = 1'b0;
		hash_match_out = 1'b0;
		wakeup_match_out = 1'b0;
	end
	// Outside the end byte the qualifiers carry the inverse, so a design sampling them late is caught.
	task automatic send(input logic [47:0] da, input logic crc, input logic hash, input logic wake);
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			b = (i < 6) ? da[47-8*i -: 8] : 8'h60 + 8'(i);
			@(posedge clk_in);
			rx_valid_out <= 1'b1;
			rx_start_out <= (i == 0);
			rx_end_out <= (i == 7);
			rx_byte_out <= b;
			rx_crc_ok_out <= (i == 7) ? crc : !crc;
			hash_match_out <= (i == 7) ? hash : !hash;
			wakeup_match_out <= (i == 7) ? wake : !wake;
		end
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_end_out <= 1'b0;
		rx_byte_out <= ~b;
		rx_crc_ok_out <= !crc;
		hash_match_out <= !hash;
		wakeup_match_out <= !wake;
	endtask : send
endmodule : rpf_rx_src

`default_nettype wire

// ---- tb/rx_packet_filter_tb.sv ----
`default_nettype none

module rx_packet_filter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] STA = 48'h02_11_22_33_44_55;
	localparam logic [47:0] ONES = 48'hff_ff_ff_ff_ff_ff;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rv, rs, re, rc, hm, wm;
	logic [7:0]  rb;
	logic        vv, fa;
	int          failures = 0;
	int          total_checks = 0;

	always #12.5 clk_in = ~clk_in;

	rpf_rx_src rpf_rx_src_inst (.clk_in(clk_in), .rx_valid_out(rv), .rx_start_out(rs), .rx_end_out(re),
		.rx_byte_out(rb), .rx_crc_ok_out(rc), .hash_match_out(hm), .wakeup_match_out(wm));
	rx_packet_filter rx_packet_filter_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .rx_valid_in(rv), .rx_start_in(rs), .rx_end_in(re),
		.rx_byte_in(rb), .rx_crc_ok_in(rc), .hash_match_in(hm), .wakeup_match_in(wm),
		.verdict_valid_out(vv), .frame_accept_out(fa));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
		check({31'h0, e}, {31'h0, experr});
	endtask : rdchk

	// A frame is judged by the single verdict pulse that follows it.
	task automatic frame(input logic [47:0] da, input logic crc, input logic h, input logic w, input logic exp);
		logic seen;
		seen = 1'b0;
		rpf_rx_src_inst.send(da, crc, h, w);
		for (int i = 0; i < 6 && !seen; i++) begin
			@(posedge clk_in);
			#1;
			if (vv === 1'b1) begin
				seen = 1'b1;
				check({31'h0, fa}, {31'h0, exp});
			end
		end
		check({31'h0, seen}, 32'h1);
	endtask : frame

	task automatic t_regs;
		rdchk(rpf_pkg::RPF_CTRL_OFS, 32'h0000_00a1, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'hffff_ff5e);
		rdchk(rpf_pkg::RPF_CTRL_OFS, 32'h0000_005e, 1'b0);
		wr(8'h20, 32'h1234_5678);
		rdchk(8'h20, 32'h0, 1'b1);
		rdchk(8'h02, 32'h0, 1'b1);
		rdchk(rpf_pkg::RPF_CTRL_OFS, 32'h0000_005e, 1'b0);
		$display("test registers done");
	endtask : t_regs

	task automatic t_reset_filter;
		frame(ONES, 1'b1, 1'b0, 1'b0, 1'b1);
		frame(ONES, 1'b0, 1'b0, 1'b0, 1'b0);
		frame(48'h0a_0b_0c_0d_0e_0f, 1'b1, 1'b1, 1'b1, 1'b0);
		$display("test reset filter done");
	endtask : t_reset_filter

	task automatic t_promisc;
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0);
		frame(48'h0a_0b_0c_0d_0e_0f, 1'b0, 1'b0, 1'b0, 1'b1);
		$display("test promiscuous done");
	endtask : t_promisc

	task automatic t_station;
		wr(rpf_pkg::RPF_STA_LO_OFS, 32'h3322_1102);
		wr(rpf_pkg::RPF_STA_HI_OFS, 32'h0000_5544);
		rdchk(rpf_pkg::RPF_STA_LO_OFS, 32'h3322_1102, 1'b0);
		rdchk(rpf_pkg::RPF_STA_HI_OFS, 32'h0000_5544, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_00c0);
		frame(STA, 1'b0, 1'b1, 1'b1, 1'b1);
		frame(STA ^ 48'h1, 1'b1, 1'b1, 1'b1, 1'b0);
		frame(STA ^ 48'h80_0000_0000, 1'b1, 1'b1, 1'b1, 1'b0);
		$display("test station done");
	endtask : t_station

	task automatic t_combine;
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_0084);
		frame(ONES, 1'b1, 1'b1, 1'b0, 1'b1);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b1);
		frame(ONES, 1'b1, 1'b0, 1'b1, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_00a4);
		frame(STA, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_004c);
		frame(ONES, 1'b1, 1'b0, 1'b1, 1'b0);
		frame(ONES, 1'b1, 1'b1, 1'b1, 1'b1);
		$display("test combine done");
	endtask : t_combine

	task automatic t_addr_kinds;
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_0002);
		frame(48'h01_00_00_00_00_00, 1'b1, 1'b0, 1'b0, 1'b1);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_0001);
		frame(48'h01_00_00_00_00_00, 1'b1, 1'b0, 1'b0, 1'b0);
		$display("test address kinds done");
	endtask : t_addr_kinds

	// Bytes 4 and 5 form one word 16'h4455, so the checksum is its complement.
	task automatic t_pattern;
		wr(rpf_pkg::RPF_PMASK_LO_OFS, 32'h0000_0030);
		wr(rpf_pkg::RPF_POFS_OFS, 32'h0);
		wr(rpf_pkg::RPF_PREF_OFS, 32'h0000_bbaa);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_0010);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b1);
		rdchk(rpf_pkg::RPF_STAT_OFS, 32'h0001_bbaa, 1'b0);
		wr(rpf_pkg::RPF_PREF_OFS, 32'h0000_bbab);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b0);
		rdchk(rpf_pkg::RPF_STAT_OFS, 32'h0000_bbaa, 1'b0);
		wr(rpf_pkg::RPF_CTRL_OFS, 32'h0000_0050);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b0);
		wr(rpf_pkg::RPF_POFS_OFS, 32'h0000_0002);
		wr(rpf_pkg::RPF_PMASK_LO_OFS, 32'h0000_000c);
		wr(rpf_pkg::RPF_PREF_OFS, 32'h0000_bbaa);
		rdchk(rpf_pkg::RPF_POFS_OFS, 32'h0000_0002, 1'b0);
		frame(STA, 1'b1, 1'b0, 1'b0, 1'b1);
		$display("test pattern done");
	endtask : t_pattern

	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	initial begin
		#200us;
		failures++;
		test_done();
	end

	initial begin
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1'b1;
		t_reset_filter();
		t_regs();
		t_promisc();
		t_station();
		t_combine();
		t_addr_kinds();
		t_pattern();
		test_done();
	end
endmodule : rx_packet_filter_tb

`default_nettype wire
